/* rtl/i2cb_cfg.svh */
// Constants for the I2C bus condition host controller
`ifndef I2CB_CFG_SVH
`define I2CB_CFG_SVH
`define I2CB_OP_WR_LOW 8'h80
`define I2CB_OP_RD_LOW 8'h81
`define I2CB_OP_WR_HIGH 8'h82
`define I2CB_OP_RD_HIGH 8'h83
`define I2CB_OP_SEND_NOW 8'h87
`define I2CB_REPEAT 3'h6
`define I2CB_COND_PHASES 2'h3
`define I2CB_SPARE_MASK 8'hF8
`define I2CB_ADR_CTRL 4'h0
`define I2CB_ADR_LOW 4'h4
`define I2CB_ADR_HIGH 4'h8
`define I2CB_ADR_STAT 4'hC
`define I2CB_ST_BUSY 0
`define I2CB_ST_TXN 1
`define I2CB_ST_RXRDY 2
`define I2CB_ST_REFUSED 3
`define I2CB_LINES_SDA_LO 2'h2
`define I2CB_LINES_BOTH_LO 2'h3
`define I2CB_LINES_SCL_LO 2'h1
`define I2CB_LINES_FREE 2'h0
`endif

/* rtl/i2cb_pkg.sv */
// Types shared by the I2C bus condition host controller
package i2cb_pkg;
  typedef enum logic [2:0] {
    I2CB_CMD_START, I2CB_CMD_STOP, I2CB_CMD_IDLE,
    I2CB_CMD_RD_LOW, I2CB_CMD_WR_HIGH, I2CB_CMD_RD_HIGH
  } i2cb_cmd_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } i2cb_beat_t;
  typedef struct packed {
    logic en;
    logic [3:0] addr;
    logic [31:0] data;
  } i2cb_reg_wr_t;
endpackage

/* rtl/i2cb_axil.sv */
// AXI4-Lite slave front end for the controller registers
module i2cb_axil
  import i2cb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output i2cb_reg_wr_t reg_wr,
  output logic [3:0] reg_rd_addr,
  input wire logic [31:0] reg_rd_data
);
  logic aw_held_r;
  logic w_held_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic bvalid_r;
  logic rvalid_r;
  logic [31:0] rdata_r;

  assign s_awready = !aw_held_r && !bvalid_r;
  assign s_wready = !w_held_r && !bvalid_r;
  assign s_bvalid = bvalid_r;
  assign s_bresp = 2'h0;
  assign s_arready = !rvalid_r;
  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = 2'h0;
  assign reg_rd_addr = s_araddr;
  assign reg_wr.en = aw_held_r && w_held_r && !bvalid_r;
  assign reg_wr.addr = {awaddr_r[3:2], 2'h0};
  assign reg_wr.data = wdata_r;

  // Address and data are caught in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 4'h0;
    end else if (s_awvalid && s_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_awaddr;
    end else if (reg_wr.en) begin
      aw_held_r <= 1'b0;
    end
  end

  // Partial strobes are written as full words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0;
    end else if (s_wvalid && s_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_wdata;
    end else if (reg_wr.en) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
    end else if (reg_wr.en) begin
      bvalid_r <= 1'b1;
    end else if (s_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
    end else if (s_arvalid && s_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= reg_rd_data;
    end else if (s_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule

/* rtl/i2cb_host.sv */
// Host controller that feeds I2C bus condition commands to a pin engine
// Contract
// - Start: pull data low, then clock low
// - After start leave clock low, data free
// - Repeat each start/stop pin write six times
// - Stop: release clock, then release data
// - Repeated start allowed inside a transaction
// - Idle write: spare pins plus both lines free
// - No idle write between start and stop
// - Low read result keeps only bits 7:3
// - High write: opcode, value, then direction
// - Every low write carries spare dir/data
// - Idle write needed before first low read
`include "i2cb_cfg.svh"
module i2cb_host
  import i2cb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output i2cb_beat_t cmd_out,
  input wire logic cmd_ready,
  input wire i2cb_beat_t rsp_in
);
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} i2cb_state_t;
  i2cb_reg_wr_t reg_wr;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;
  i2cb_state_t state_r;
  i2cb_cmd_t cmd_r, go_cmd;
  logic [4:0] low_dat_r, low_dir_r;
  logic [7:0] hi_val_r, hi_dir_r, rx_byte_r, byte_r;
  logic in_txn_r, idle_done_r, rx_rdy_r, refused_r;
  logic seq_done, fire, go_wr, go_ok;
  logic [1:0] phase_r, idx_r, phase_nxt, idx_nxt;
  logic [2:0] rep_r, rep_nxt;

  i2cb_axil u_axil (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .reg_wr(reg_wr), .reg_rd_addr(rd_addr),
    .reg_rd_data(rd_data)
  );

  function automatic logic [1:0] lines(i2cb_cmd_t c, logic [1:0] ph);
    logic [1:0] l;
    l = `I2CB_LINES_FREE;
    if (c == I2CB_CMD_START) begin
      unique case (ph)
        2'h0: l = `I2CB_LINES_SDA_LO;
        2'h1: l = `I2CB_LINES_BOTH_LO;
        default: l = `I2CB_LINES_SCL_LO;
      endcase
    end else if (c == I2CB_CMD_STOP) begin
      unique case (ph)
        2'h0: l = `I2CB_LINES_BOTH_LO;
        2'h1: l = `I2CB_LINES_SDA_LO;
        default: l = `I2CB_LINES_FREE;
      endcase
    end
    return l;
  endfunction

  function automatic logic [7:0] gen_byte(i2cb_cmd_t c, logic [1:0] ph,
                                          logic [1:0] ix);
    logic [7:0] b;
    b = `I2CB_OP_SEND_NOW;
    unique case (c)
      I2CB_CMD_RD_LOW: if (ix == 2'h0) b = `I2CB_OP_RD_LOW;
      I2CB_CMD_RD_HIGH: if (ix == 2'h0) b = `I2CB_OP_RD_HIGH;
      I2CB_CMD_WR_HIGH: begin
        // Value then direction; low port untouched
        unique case (ix)
          2'h0: b = `I2CB_OP_WR_HIGH;
          2'h1: b = hi_val_r;
          default: b = hi_dir_r;
        endcase
      end
      default: begin
        // Released lines carry value 0 and direction 0
        unique case (ix)
          2'h0: b = `I2CB_OP_WR_LOW;
          2'h1: b = {low_dat_r, 3'h0};
          default: b = {low_dir_r, 1'b0, lines(c, ph)};
        endcase
      end
    endcase
    return b;
  endfunction

  assign fire = cmd_out.valid && cmd_ready;
  assign cmd_out.valid = (state_r == ST_SEND);
  assign cmd_out.data = byte_r;
  assign go_cmd = i2cb_cmd_t'(reg_wr.data[2:0]);
  assign go_wr = reg_wr.en && (reg_wr.addr == `I2CB_ADR_CTRL);
  assign go_ok = go_wr && (state_r == ST_IDLE)
                 && (reg_wr.data[2:0] <= 3'(I2CB_CMD_RD_HIGH))
                 && !(go_cmd == I2CB_CMD_IDLE && in_txn_r)
                 && !(go_cmd == I2CB_CMD_RD_LOW && !idle_done_r);

  always_comb begin
    logic [1:0] last_ix;
    logic [2:0] reps;
    logic [1:0] nph;
    last_ix = (cmd_r == I2CB_CMD_RD_LOW || cmd_r == I2CB_CMD_RD_HIGH)
              ? 2'h1 : 2'h2;
    reps = (cmd_r == I2CB_CMD_START || cmd_r == I2CB_CMD_STOP)
           ? `I2CB_REPEAT : 3'h1;
    nph = (cmd_r == I2CB_CMD_START || cmd_r == I2CB_CMD_STOP)
          ? `I2CB_COND_PHASES : 2'h1;
    idx_nxt = idx_r + 2'h1;
    rep_nxt = rep_r;
    phase_nxt = phase_r;
    seq_done = 1'b0;
    if (idx_r == last_ix) begin
      idx_nxt = 2'h0;
      rep_nxt = rep_r + 3'h1;
      if (rep_r == reps - 3'h1) begin
        rep_nxt = 3'h0;
        phase_nxt = phase_r + 2'h1;
        seq_done = (phase_r == nph - 2'h1);
      end
    end
  end

  // Sequencer: one command at a time, bytes strictly in order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cmd_r <= I2CB_CMD_IDLE;
      phase_r <= 2'h0;
      rep_r <= 3'h0;
      idx_r <= 2'h0;
      byte_r <= 8'h00;
    end else begin
      unique case (state_r)
        ST_IDLE: if (go_ok) begin
          state_r <= ST_SEND;
          cmd_r <= go_cmd;
          phase_r <= 2'h0;
          rep_r <= 3'h0;
          idx_r <= 2'h0;
          byte_r <= gen_byte(go_cmd, 2'h0, 2'h0);
        end
        ST_SEND: if (fire) begin
          phase_r <= phase_nxt;
          rep_r <= rep_nxt;
          idx_r <= idx_nxt;
          byte_r <= gen_byte(cmd_r, phase_nxt, idx_nxt);
          if (seq_done) begin
            state_r <= (cmd_r == I2CB_CMD_RD_LOW
                        || cmd_r == I2CB_CMD_RD_HIGH) ? ST_WAIT : ST_IDLE;
          end
        end
        ST_WAIT: if (rsp_in.valid) begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Transaction tracking; a start inside one is a repeated start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_txn_r <= 1'b0;
      idle_done_r <= 1'b0;
    end else if (state_r == ST_SEND && fire && seq_done) begin
      if (cmd_r == I2CB_CMD_START) in_txn_r <= 1'b1;
      if (cmd_r == I2CB_CMD_STOP) in_txn_r <= 1'b0;
      if (cmd_r == I2CB_CMD_IDLE) idle_done_r <= 1'b1;
    end
  end

  // Response capture; low read keeps only spare pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_byte_r <= 8'h00;
    end else if (state_r == ST_WAIT && rsp_in.valid) begin
      rx_byte_r <= (cmd_r == I2CB_CMD_RD_LOW)
                   ? (rsp_in.data & `I2CB_SPARE_MASK) : rsp_in.data;
    end
  end

  // Sticky flags: write one clears, a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_rdy_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (reg_wr.en && reg_wr.addr == `I2CB_ADR_STAT) begin
        if (reg_wr.data[`I2CB_ST_RXRDY]) rx_rdy_r <= 1'b0;
        if (reg_wr.data[`I2CB_ST_REFUSED]) refused_r <= 1'b0;
      end
      if (state_r == ST_WAIT && rsp_in.valid) rx_rdy_r <= 1'b1;
      if (go_wr && !go_ok) refused_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_dat_r <= 5'h00;
      low_dir_r <= 5'h00;
      hi_val_r <= 8'h00;
      hi_dir_r <= 8'h00;
    end else if (reg_wr.en && reg_wr.addr == `I2CB_ADR_LOW) begin
      low_dat_r <= reg_wr.data[4:0];
      low_dir_r <= reg_wr.data[12:8];
    end else if (reg_wr.en && reg_wr.addr == `I2CB_ADR_HIGH) begin
      hi_val_r <= reg_wr.data[7:0];
      hi_dir_r <= reg_wr.data[15:8];
    end
  end

  always_comb begin
    unique case ({rd_addr[3:2], 2'h0})
      `I2CB_ADR_CTRL: rd_data = {29'h0, cmd_r};
      `I2CB_ADR_LOW: rd_data = {19'h0, low_dir_r, 3'h0, low_dat_r};
      `I2CB_ADR_HIGH: rd_data = {16'h0, hi_dir_r, hi_val_r};
      default: rd_data = {16'h0, rx_byte_r, 4'h0, refused_r, rx_rdy_r,
                          in_txn_r, state_r != ST_IDLE};
    endcase
  end

  property p_start_order;
    @(posedge aclk) disable iff (!aresetn)
    cmd_out.valid && cmd_r == I2CB_CMD_START && idx_r == 2'h2
      |-> cmd_out.data[1:0] == lines(I2CB_CMD_START, phase_r);
  endproperty
  a_start_order: assert property (p_start_order)
    else $error("start lines out of order");

  property p_start_end;
    @(posedge aclk) disable iff (!aresetn)
    fire && seq_done && cmd_r == I2CB_CMD_START
      |-> cmd_out.data[1:0] == `I2CB_LINES_SCL_LO ##1 in_txn_r;
  endproperty
  a_start_end: assert property (p_start_end)
    else $error("start does not end in transaction idle");

  property p_six_reps;
    @(posedge aclk) disable iff (!aresetn)
    fire && state_r == ST_SEND && phase_nxt != phase_r
      && (cmd_r == I2CB_CMD_START || cmd_r == I2CB_CMD_STOP)
      |-> rep_r == `I2CB_REPEAT - 3'h1;
  endproperty
  a_six_reps: assert property (p_six_reps)
    else $error("condition phase not repeated six times");

  property p_stop_order;
    @(posedge aclk) disable iff (!aresetn)
    fire && seq_done && cmd_r == I2CB_CMD_STOP
      |-> cmd_out.data[1:0] == `I2CB_LINES_FREE ##1 !in_txn_r;
  endproperty
  a_stop_order: assert property (p_stop_order)
    else $error("stop does not release both lines");

  property p_no_idle_in_txn;
    @(posedge aclk) disable iff (!aresetn)
    go_wr && go_cmd == I2CB_CMD_IDLE && in_txn_r
      |=> refused_r && !$rose(cmd_out.valid);
  endproperty
  a_no_idle_in_txn: assert property (p_no_idle_in_txn)
    else $error("idle write accepted inside a transaction");
  property p_low_mask;
    @(posedge aclk) disable iff (!aresetn)
    state_r == ST_WAIT && rsp_in.valid && cmd_r == I2CB_CMD_RD_LOW
      |=> rx_byte_r[2:0] == 3'h0 && rx_rdy_r;
  endproperty
  a_low_mask: assert property (p_low_mask)
    else $error("low read result not masked");

  property p_high_layout;
    @(posedge aclk) disable iff (!aresetn)
    fire && cmd_r == I2CB_CMD_WR_HIGH && idx_r == 2'h0
      |-> cmd_out.data == `I2CB_OP_WR_HIGH
      ##1 cmd_out.data == hi_val_r;
  endproperty
  a_high_layout: assert property (p_high_layout)
    else $error("high write bytes out of order");

  property p_spare_bits;
    @(posedge aclk) disable iff (!aresetn)
    cmd_out.valid && idx_r == 2'h2 && cmd_r inside
      {I2CB_CMD_START, I2CB_CMD_STOP, I2CB_CMD_IDLE}
      |-> cmd_out.data[7:3] == low_dir_r && cmd_out.data[2] == 1'b0;
  endproperty
  a_spare_bits: assert property (p_spare_bits)
    else $error("low write lacks spare pin directions");

  property p_no_high_drive;
    @(posedge aclk) disable iff (!aresetn)
    cmd_out.valid && idx_r == 2'h1 && cmd_r inside
      {I2CB_CMD_START, I2CB_CMD_STOP, I2CB_CMD_IDLE}
      |-> cmd_out.data[2:0] == 3'h0 && cmd_out.data[7:3] == low_dat_r;
  endproperty
  a_no_high_drive: assert property (p_no_high_drive)
    else $error("bus line value driven high");

  property p_read_gate;
    @(posedge aclk) disable iff (!aresetn)
    go_wr && go_cmd == I2CB_CMD_RD_LOW && !idle_done_r
      |=> refused_r && !$rose(cmd_out.valid);
  endproperty
  a_read_gate: assert property (p_read_gate)
    else $error("low read before any idle write");
  property p_beat_hold;
    @(posedge aclk) disable iff (!aresetn)
    cmd_out.valid && !cmd_ready |=> cmd_out.valid && $stable(byte_r);
  endproperty
  a_beat_hold: assert property (p_beat_hold)
    else $error("command byte changed before taken");
endmodule

/* tb/i2cb_engine_model.sv */
// Behavioural pin engine that executes the controller byte stream
module i2cb_engine_model
  import i2cb_pkg::*;
#(
  parameter logic [7:0] LOW_EXT = 8'h97,
  parameter logic [7:0] HIGH_EXT = 8'hA5
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire i2cb_beat_t cmd,
  output logic cmd_ready,
  output i2cb_beat_t rsp,
  input wire logic slow,
  output logic scl,
  output logic sda,
  output logic [7:0] hi_pins,
  output logic [15:0] n_low_wr,
  output logic bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] st;
  logic [7:0] op, arg, low_v, low_d, hi_v, hi_d, held, low_pins;
  logic pend, seen, tog;
  // Stalls every other cycle when slow
  assign cmd_ready = !slow || tog;
  // Undriven pins show the outside level, bus lines pulled up
  assign low_pins = (low_v & low_d) | (LOW_EXT & ~low_d);
  assign hi_pins = (hi_v & hi_d) | (HIGH_EXT & ~hi_d);
  assign scl = low_pins[0];
  assign sda = low_pins[1];
  always_ff @(posedge aclk) begin
    rsp.valid <= 1'h0;
    rsp.data <= ~rsp.data;
    tog <= !tog;
    if (!aresetn) begin
      st <= 2'h0;
      low_v <= 8'h00;
      low_d <= 8'h00;
      hi_v <= 8'h00;
      hi_d <= 8'h00;
      pend <= 1'h0;
      seen <= 1'h0;
      n_low_wr <= 16'h0000;
      bad <= 1'h0;
      tog <= 1'h0;
      rsp.data <= 8'h00;
    end else if (cmd.valid && cmd_ready) begin
      // Bytes are executed strictly in arrival order
      case (st)
        2'h0: begin
          op <= cmd.data;
          case (cmd.data)
            8'h80, 8'h82: st <= 2'h1;
            8'h81: begin
              pend <= 1'h1;
              held <= low_pins;
              if (!seen) bad <= 1'h1;
            end
            8'h83: begin
              pend <= 1'h1;
              held <= hi_pins;
            end
            8'h87: begin
              rsp.valid <= pend;
              rsp.data <= held;
              pend <= 1'h0;
            end
            default: bad <= 1'h1;
          endcase
        end
        2'h1: begin
          arg <= cmd.data;
          st <= 2'h2;
        end
        default: begin
          st <= 2'h0;
          if (op == 8'h80) begin
            low_v <= arg;
            low_d <= cmd.data;
            n_low_wr <= n_low_wr + 16'h0001;
            seen <= 1'h1;
            if ((arg[1:0] & cmd.data[1:0]) != 2'h0) bad <= 1'h1;
          end else begin
            hi_v <= arg;
            hi_d <= cmd.data;
          end
        end
      endcase
    end
  end
endmodule

/* tb/i2cb_host_tb.sv */
// Self-checking bench for the bus condition host controller
`include "i2cb_cfg.svh"
module i2cb_host_tb
  import i2cb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] code;
    logic [31:0] hi;
    logic [7:0] pins;
    logic [1:0] lines;
    logic [7:0] rd;
  } i2cb_row_t;
  i2cb_row_t rows [6] = '{
    '{3'h2, 32'h0, 8'hA5, 2'h3, 8'h0},
    '{3'h4, 32'h0F3C, 8'hAC, 2'h3, 8'h0},
    '{3'h5, 32'h0F3C, 8'hAC, 2'h3, 8'hAC},
    '{3'h4, 32'hFF5A, 8'h5A, 2'h3, 8'h0},
    '{3'h5, 32'hFF5A, 8'h5A, 2'h3, 8'h5A},
    '{3'h3, 32'hFF5A, 8'h5A, 2'h3, 8'h50}};
  logic aclk = 1'h0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
  logic awready, wready, bvalid, arready, rvalid, cmd_ready, scl, sda, bad;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] hi_pins;
  logic [15:0] n_low_wr;
  i2cb_beat_t cmd, rsp;
  logic scl_q = 1'h1;
  logic sda_q = 1'h1;
  int n_start = 0;
  int n_stop = 0;
  int n_mismatch = 0;
  int checks_done = 0;
  always #12.5 aclk = ~aclk;
  i2cb_host i_i2cb_host (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
    .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .cmd_out(cmd),
    .cmd_ready(cmd_ready), .rsp_in(rsp));
  i2cb_engine_model i_i2cb_engine_model (.aclk(aclk), .aresetn(aresetn),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp), .slow(slow), .scl(scl),
    .sda(sda), .hi_pins(hi_pins), .n_low_wr(n_low_wr), .bad(bad));
  // Counts start and stop conditions seen on the bus lines
  always @(posedge aclk) begin
    if (scl && scl_q && sda_q && !sda) n_start++;
    if (scl && scl_q && !sda_q && sda) n_stop++;
    scl_q <= scl;
    sda_q <= sda;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready === 1'h1;
      tw = wvalid && wready === 1'h1;
      tb = bvalid === 1'h1;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    tr = 1'h0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready === 1'h1;
      tr = rvalid === 1'h1;
      d = rdata;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
    end
  endtask
  // Launches a command and polls status until the controller is idle
  task automatic run(input logic [2:0] code, output logic [31:0] st);
    int n;
    axi_wr(`I2CB_ADR_CTRL, {29'h0, code});
    n = 0;
    st = 32'h1;
    while (st[0] !== 1'h0 && n < 400) begin
      axi_rd(`I2CB_ADR_STAT, st);
      n++;
    end
    chk("busy wait", 0, n / 400);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end
  initial begin
    logic [31:0] st, d;
    int s0;
    logic [15:0] w0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h00;
    {awaddr, araddr, wdata} = 40'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    for (int a = 0; a < 4; a++) begin
      axi_rd(4'(a * 4), d);
      chk("reset value", (a == 0) ? {29'h0, I2CB_CMD_IDLE} : 32'h0, d);
    end
    run(3'h3, st);
    chk("early low read refused", 1, st[3]);
    axi_wr(`I2CB_ADR_STAT, 32'h8);
    axi_rd(`I2CB_ADR_STAT, st);
    chk("refused cleared", 0, st[3]);
    axi_wr(`I2CB_ADR_LOW, 32'h1C0B);
    done("reset");
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      axi_wr(`I2CB_ADR_HIGH, rows[i].hi);
      run(rows[i].code, st);
      chk("high pins", rows[i].pins, hi_pins);
      chk("bus lines", rows[i].lines, {sda, scl});
      chk("refused", 0, st[3]);
      if (rows[i].code inside {3'h3, 3'h5})
        chk("read byte", rows[i].rd, st[15:8]);
    end
    done("table");
    slow <= 1'h1;
    w0 = n_low_wr;
    s0 = n_start;
    axi_wr(`I2CB_ADR_CTRL, 32'h0);
    run(3'h4, st);
    chk("busy refused", 1, st[3]);
    chk("in transaction", 1, st[1]);
    chk("start writes", 18, n_low_wr - w0);
    chk("start seen", 1, n_start - s0);
    chk("lines after start", 2'h2, {sda, scl});
    axi_wr(`I2CB_ADR_STAT, 32'hC);
    run(3'h2, st);
    chk("idle in transaction", 1, st[3]);
    chk("lines kept", 2'h2, {sda, scl});
    axi_wr(`I2CB_ADR_STAT, 32'h8);
    axi_wr(`I2CB_ADR_HIGH, 32'hF00F);
    run(3'h4, st);
    chk("high pins in transaction", 8'h05, hi_pins);
    chk("lines untouched", 2'h2, {sda, scl});
    done("start");
    w0 = n_low_wr;
    run(3'h0, st);
    chk("repeat start writes", 18, n_low_wr - w0);
    chk("repeat start state", 3'h5, {sda, scl, st[1]});
    w0 = n_low_wr;
    s0 = n_stop;
    run(3'h1, st);
    chk("stop writes", 18, n_low_wr - w0);
    chk("stop seen", 1, n_stop - s0);
    chk("after stop", 3'h6, {sda, scl, st[1]});
    chk("spare pins", 10'h38B, {i_i2cb_engine_model.low_d[7:3],
      i_i2cb_engine_model.low_v[7:3]});
    done("stop");
    for (int c = 6; c < 8; c++) begin
      run(3'(c), st);
      chk("bad code refused", 1, st[3]);
      axi_wr(`I2CB_ADR_STAT, 32'h8);
    end
    axi_rd(4'h6, d);
    chk("alias read", 32'h1C0B, d);
    chk("responses", 32'h0, {bresp, rresp});
    chk("engine faults", 0, bad);
    done("refusals");
    summarize();
  end
endmodule
